/* core/can_synced_position_loop.sv */
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1: In mode 15 run proportional position loop with feed-forward from CAN references.
// RULE2: Feedback source select 0 uses resolver, 1 uses encoder.
// RULE3: Speed request equals position loop output plus active feed-forward.
// RULE4: Sync copies received feed-forward into active feed-forward.
// RULE5: Sync copies received position reference into active position reference.
// RULE6: Sync copies current motor position into transmit position register.
// RULE7: Sync sets sync flag; device clears it after the update.
// RULE8: Type 0 sync with type-0 enable transmits sampled position.
// RULE9: Type 1 sync with type-1 enable transmits sampled position.
// RULE10: Reply carries full 16-bit status, or low 8 bits when short.
// RULE11: With bit-rate select zero, low-speed bit picks 500k, else 1M.
// RULE12: Type 1 reset zeroes motor position and references.
// RULE13: Type 2 reset loads shaft angle, clears error accumulator pair; the code clears its one accumulator, POSITION_ERROR_ACC.
// RULE14: Type 3 reset copies motor position to reference, clears accumulator.
// RULE15: Reset command bits clear themselves once applied.
module can_synced_position_loop
  import pos_loop_pkg::*;
#(
  parameter int GAIN_SHIFT = 4
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [3:0] OP_MODE,
  input wire logic FB_SOURCE_SELECT,
  input wire logic [15:0] BIT_RATE_SELECT,
  input wire logic [15:0] POS_GAIN,
  input wire logic signed [31:0] RESOLVER_POS,
  input wire logic signed [31:0] ENCODER_POS,
  input wire logic signed [31:0] SHAFT_ANGLE,
  input wire logic SYNC_RX,
  input wire logic [1:0] SYNC_RX_TYPE,
  input wire logic REG_WR,
  input wire logic [3:0] REG_ADDR,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic signed [15:0] SPEED_REQUEST,
  output logic signed [31:0] CURRENT_MOTOR_POSITION,
  output logic signed [31:0] POSITION_ERROR_ACC,
  output logic FB_TX_VALID,
  output logic [31:0] FB_TX_POSITION,
  output logic [15:0] REPLY_STATUS,
  output logic REPLY_SHORT,
  output logic RATE_LOW_SPEED,
  output logic RATE_DEFAULT_SELECTED
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [15:0] can_status_word_a;
  logic [15:0] can_status_word_b;
  logic signed [15:0] active_feedforward_speed;
  logic signed [15:0] received_feedforward_speed;
  logic signed [31:0] received_position_reference;
  logic signed [31:0] motor_position_for_transmit;
  logic signed [31:0] active_position_reference;
  logic [15:0] mode_control_bits;
  logic signed [31:0] feedback_pos;
  logic signed [31:0] pos_offset;
  logic mode_active;
  logic sync_pending;
  sync_type_e sync_kind;
  feedback_s tx;
  reply_s reply;
  logic do_zero;
  logic do_shaft;
  logic do_follow;

  assign mode_active = (OP_MODE == MODE_CAN_POSITION); // [RULE1]
  assign feedback_pos = FB_SOURCE_SELECT ? ENCODER_POS : RESOLVER_POS; // [RULE2]
  assign do_zero = mode_control_bits[ZERO_RESET_BIT];
  assign do_shaft = mode_control_bits[SHAFT_RESET_BIT];
  assign do_follow = mode_control_bits[FOLLOW_RESET_BIT];

  // ------------------------------------------------------------
  // Motor position: raw feedback plus an offset moved by resets
  // ------------------------------------------------------------
  // The offset lets the reset commands redefine position without
  // touching the sensor counters themselves.
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pos_offset <= RESET_LONG;
    end else if (CE) begin
      if (do_zero) begin
        pos_offset <= -feedback_pos; // [RULE12]
      end else if (do_shaft) begin
        pos_offset <= SHAFT_ANGLE - feedback_pos; // [RULE13]
      end
    end
  end

  assign CURRENT_MOTOR_POSITION = feedback_pos + pos_offset;

  // ------------------------------------------------------------
  // Sync capture: flag set by link, cleared after the copy
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sync_pending <= 1'b0;
      sync_kind <= SYNC_TYPE0;
    end else if (CE) begin
      if (SYNC_RX) begin
        sync_pending <= 1'b1; // [RULE7]
        sync_kind <= sync_type_e'(SYNC_RX_TYPE);
      end else if (sync_pending) begin
        sync_pending <= 1'b0; // [RULE7]
      end
    end
  end

  // Active references and transmit sample
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      active_feedforward_speed <= RESET_WORD;
      active_position_reference <= RESET_LONG;
      motor_position_for_transmit <= RESET_LONG;
    end else if (CE) begin
      if (do_zero) begin
        active_position_reference <= RESET_LONG; // [RULE12]
        motor_position_for_transmit <= RESET_LONG; // [RULE12]
      end else if (do_shaft) begin
        active_position_reference <= SHAFT_ANGLE; // [RULE13]
      end else if (do_follow) begin
        active_position_reference <= CURRENT_MOTOR_POSITION; // [RULE14]
      end else if (sync_pending) begin
        active_feedforward_speed <= received_feedforward_speed; // [RULE4]
        active_position_reference <= received_position_reference; // [RULE5]
        motor_position_for_transmit <= CURRENT_MOTOR_POSITION; // [RULE6]
      end else if (REG_WR) begin
        if (REG_ADDR == REG_ACTIVE_FF) begin
          active_feedforward_speed <= REG_WDATA;
        end
        if (REG_ADDR == REG_TX_POS_LO) begin
          motor_position_for_transmit[15:0] <= REG_WDATA;
        end
        if (REG_ADDR == REG_TX_POS_HI) begin
          motor_position_for_transmit[31:16] <= REG_WDATA;
        end
      end
    end
  end

  // Position-error accumulator
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      POSITION_ERROR_ACC <= RESET_LONG;
    end else if (CE) begin
      if (do_zero || do_shaft || do_follow) begin
        POSITION_ERROR_ACC <= RESET_LONG; // [RULE13] [RULE14]
      end else if (mode_active) begin
        POSITION_ERROR_ACC <= POSITION_ERROR_ACC
          + (active_position_reference - CURRENT_MOTOR_POSITION);
      end
    end
  end

  // ------------------------------------------------------------
  // Feedback transmission on sync
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      tx <= '0;
    end else if (CE) begin
      tx.valid <= 1'b0;
      if (sync_pending && mode_active && !do_zero && !do_shaft && !do_follow) begin
        if ((sync_kind == SYNC_TYPE0 && mode_control_bits[FB_TYPE0_EN_BIT]) // [RULE8]
            || (sync_kind == SYNC_TYPE1 && mode_control_bits[FB_TYPE1_EN_BIT])) begin // [RULE9]
          tx.valid <= 1'b1;
          tx.position <= CURRENT_MOTOR_POSITION;
        end
      end
    end
  end

  assign FB_TX_VALID = tx.valid;
  assign FB_TX_POSITION = tx.position;

  // ------------------------------------------------------------
  // Register writes from the parameter port
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      can_status_word_a <= RESET_WORD;
      can_status_word_b <= RESET_WORD;
      received_feedforward_speed <= RESET_WORD;
      received_position_reference <= RESET_LONG;
    end else if (CE && REG_WR) begin
      case (REG_ADDR)
        REG_STATUS_A: can_status_word_a <= REG_WDATA;
        REG_STATUS_B: can_status_word_b <= REG_WDATA;
        REG_RECEIVED_FF: received_feedforward_speed <= REG_WDATA;
        REG_RX_POS_LO: received_position_reference[15:0] <= REG_WDATA;
        REG_RX_POS_HI: received_position_reference[31:16] <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Mode control: sync bit mirrors the pending flag, reset commands self-clear
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      mode_control_bits <= RESET_WORD;
    end else if (CE) begin
      if (REG_WR && REG_ADDR == REG_MODE_CTRL) begin
        mode_control_bits <= REG_WDATA;
        mode_control_bits[SYNC_FLAG_BIT] <= REG_WDATA[SYNC_FLAG_BIT] | SYNC_RX;
      end else begin
        mode_control_bits[SYNC_FLAG_BIT] <= SYNC_RX; // [RULE7]
        mode_control_bits[ZERO_RESET_BIT] <= 1'b0; // [RULE15]
        mode_control_bits[SHAFT_RESET_BIT] <= 1'b0; // [RULE15]
        mode_control_bits[FOLLOW_RESET_BIT] <= 1'b0; // [RULE15]
      end
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb begin
    case (REG_ADDR)
      REG_STATUS_A: REG_RDATA = can_status_word_a;
      REG_STATUS_B: REG_RDATA = can_status_word_b;
      REG_ACTIVE_FF: REG_RDATA = active_feedforward_speed;
      REG_RECEIVED_FF: REG_RDATA = received_feedforward_speed;
      REG_RX_POS_LO: REG_RDATA = received_position_reference[15:0];
      REG_RX_POS_HI: REG_RDATA = received_position_reference[31:16];
      REG_TX_POS_LO: REG_RDATA = motor_position_for_transmit[15:0];
      REG_TX_POS_HI: REG_RDATA = motor_position_for_transmit[31:16];
      REG_MODE_CTRL: REG_RDATA = mode_control_bits;
      REG_ACTIVE_REF_LO: REG_RDATA = active_position_reference[15:0];
      REG_ACTIVE_REF_HI: REG_RDATA = active_position_reference[31:16];
      default: REG_RDATA = 16'h0000;
    endcase
  end

  // ------------------------------------------------------------
  // Link rate: only decided here when the rate parameter is zero
  // ------------------------------------------------------------
  assign RATE_DEFAULT_SELECTED = (BIT_RATE_SELECT == 16'h0000);
  assign RATE_LOW_SPEED = RATE_DEFAULT_SELECTED && mode_control_bits[LOW_SPEED_BIT]; // [RULE11]

  // ------------------------------------------------------------
  // Submodules
  // ------------------------------------------------------------
  position_loop_p #(
    .GAIN_SHIFT(GAIN_SHIFT)
  ) u_loop (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .enable(mode_active),
    .reference(active_position_reference),
    .feedback(CURRENT_MOTOR_POSITION),
    .feedforward(active_feedforward_speed),
    .gain(POS_GAIN),
    .speed_req(SPEED_REQUEST)
  );

  reply_formatter u_reply (
    .clk(MCLK),
    .rst(RST),
    .ce(CE),
    .status_word(can_status_word_b),
    .short_sel(mode_control_bits[REPLY_SHORT_BIT]),
    .reply(reply)
  );

  assign REPLY_STATUS = reply.status;
  assign REPLY_SHORT = reply.short_status;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sync_clears_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE7]
    (CE && SYNC_RX) ##1 (CE && !SYNC_RX) |=> !sync_pending)
    else $error("sync flag not cleared");
  // A mode write may set the flag bit itself, so only idle cycles are checked
  flag_clear_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE7]
    (CE && mode_control_bits[SYNC_FLAG_BIT] && !SYNC_RX
     && !(REG_WR && REG_ADDR == REG_MODE_CTRL)) |=> !mode_control_bits[SYNC_FLAG_BIT])
    else $error("sync flag bit stuck");
  // Reset commands win over a pending sync, so the copy checks leave them out
  ff_copy_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE4]
    (CE && sync_pending && !do_zero && !do_shaft && !do_follow)
    |=> active_feedforward_speed == $past(received_feedforward_speed))
    else $error("feed-forward not copied");
  ref_copy_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE5]
    (CE && sync_pending && !do_zero && !do_shaft && !do_follow)
    |=> active_position_reference == $past(received_position_reference))
    else $error("reference not copied");
  tx_sample_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE6]
    (CE && sync_pending && !do_zero && !do_shaft && !do_follow)
    |=> motor_position_for_transmit == $past(CURRENT_MOTOR_POSITION))
    else $error("motor position not sampled");
  type0_tx_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE8]
    (CE && sync_pending && mode_active && sync_kind == SYNC_TYPE0
     && mode_control_bits[FB_TYPE0_EN_BIT] && !do_zero && !do_shaft && !do_follow)
    |=> FB_TX_VALID)
    else $error("type 0 feedback missing");
  type1_tx_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE9]
    (CE && sync_pending && mode_active && sync_kind == SYNC_TYPE1
     && mode_control_bits[FB_TYPE1_EN_BIT] && !do_zero && !do_shaft && !do_follow)
    |=> FB_TX_VALID)
    else $error("type 1 feedback missing");
  speed_off_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE1]
    (CE && !mode_active) |=> SPEED_REQUEST == 16'sh0000)
    else $error("speed request outside mode 15");
  zero_reset_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE12]
    (CE && do_zero) |=> active_position_reference == 32'h00000000)
    else $error("type 1 reset failed");
  zero_pos_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE12]
    (CE && do_zero) |=> pos_offset == -$past(feedback_pos)
    && motor_position_for_transmit == 32'h00000000)
    else $error("type 1 reset left a position");
  shaft_reset_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE13]
    (CE && !do_zero && do_shaft) |=> POSITION_ERROR_ACC == 32'h00000000)
    else $error("type 2 reset failed");
  shaft_ref_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE13]
    (CE && !do_zero && do_shaft) |=> active_position_reference == $past(SHAFT_ANGLE)
    && pos_offset == $past(SHAFT_ANGLE) - $past(feedback_pos))
    else $error("type 2 reset missed the shaft angle");
  follow_ref_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE14]
    (CE && !do_zero && !do_shaft && do_follow)
    |=> active_position_reference == $past(CURRENT_MOTOR_POSITION)
    && POSITION_ERROR_ACC == 32'h00000000)
    else $error("type 3 reset failed");
  cmd_clear_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE15]
    (CE && (do_zero || do_shaft || do_follow) && !(REG_WR && REG_ADDR == REG_MODE_CTRL))
    |=> !do_zero && !do_shaft && !do_follow)
    else $error("reset command not self-cleared");
  rate_low_a: assert property (@(posedge MCLK) disable iff (RST) // [RULE11]
    (BIT_RATE_SELECT != 16'h0000) |-> !RATE_LOW_SPEED)
    else $error("rate choice outside default");

  sync_seen_c: cover property (@(posedge MCLK) disable iff (RST) CE && sync_pending);
  tx_seen_c: cover property (@(posedge MCLK) disable iff (RST) FB_TX_VALID);
  follow_seen_c: cover property (@(posedge MCLK) disable iff (RST) CE && do_follow);
  shaft_seen_c: cover property (@(posedge MCLK) disable iff (RST) CE && do_shaft);
  zero_seen_c: cover property (@(posedge MCLK) disable iff (RST) CE && do_zero);

endmodule
`default_nettype wire

/* core/pos_loop_pkg.sv */
package pos_loop_pkg;

  // ------------------------------------------------------------
  // Operating mode and control-bit field positions
  // ------------------------------------------------------------
  localparam logic [3:0] MODE_CAN_POSITION = 4'hf;
  localparam int FB_TYPE0_EN_BIT = 2;
  localparam int REPLY_SHORT_BIT = 3;
  localparam int LOW_SPEED_BIT = 4;
  localparam int FB_TYPE1_EN_BIT = 6;
  localparam int SYNC_FLAG_BIT = 8;
  localparam int ZERO_RESET_BIT = 10;
  localparam int SHAFT_RESET_BIT = 11;
  localparam int FOLLOW_RESET_BIT = 12;

  // ------------------------------------------------------------
  // Register indices on the parameter port and reset values
  // ------------------------------------------------------------
  localparam logic [3:0] REG_STATUS_A = 4'h0;
  localparam logic [3:0] REG_STATUS_B = 4'h1;
  localparam logic [3:0] REG_ACTIVE_FF = 4'h2;
  localparam logic [3:0] REG_RECEIVED_FF = 4'h3;
  localparam logic [3:0] REG_RX_POS_LO = 4'h4;
  localparam logic [3:0] REG_RX_POS_HI = 4'h5;
  localparam logic [3:0] REG_TX_POS_LO = 4'h6;
  localparam logic [3:0] REG_TX_POS_HI = 4'h7;
  localparam logic [3:0] REG_MODE_CTRL = 4'h8;
  localparam logic [3:0] REG_ACTIVE_REF_LO = 4'h9;
  localparam logic [3:0] REG_ACTIVE_REF_HI = 4'ha;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [31:0] RESET_LONG = 32'h00000000;

  // ------------------------------------------------------------
  // Link bit rates
  // ------------------------------------------------------------
  localparam int RATE_LOW_KBPS = 500;
  localparam int RATE_HIGH_KBPS = 1000;

  typedef enum logic [1:0] {
    SYNC_TYPE0 = 2'h0,
    SYNC_TYPE1 = 2'h1
  } sync_type_e;

  typedef struct packed {
    logic [15:0] status;
    logic short_status;
  } reply_s;

  typedef struct packed {
    logic [31:0] position;
    logic valid;
  } feedback_s;

endpackage

/* core/reply_formatter.sv */
`timescale 1ns/1ps
`default_nettype none
module reply_formatter
  import pos_loop_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] status_word,
  input wire logic short_sel,
  output reply_s reply
);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reply <= '0;
    end else if (ce) begin
      reply.short_status <= short_sel;
      if (short_sel) begin
        reply.status <= {8'h00, status_word[7:0]}; // [RULE10]
      end else begin
        reply.status <= status_word; // [RULE10]
      end
    end
  end

endmodule
`default_nettype wire

/* core/position_loop_p.sv */
`timescale 1ns/1ps
`default_nettype none
module position_loop_p
  import pos_loop_pkg::*;
#(
  parameter int GAIN_SHIFT = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic signed [31:0] reference,
  input wire logic signed [31:0] feedback,
  input wire logic signed [15:0] feedforward,
  input wire logic [15:0] gain,
  output logic signed [15:0] speed_req
);

  logic signed [31:0] err;
  logic signed [47:0] prod;
  logic signed [47:0] sum;

  always_comb begin
    err = reference - feedback;
    prod = (48'(err) * 48'(signed'({1'b0, gain}))) >>> GAIN_SHIFT;
    sum = prod + 48'(feedforward); // [RULE3]
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      speed_req <= 16'sh0000;
    end else if (ce) begin
      if (!enable) begin
        speed_req <= 16'sh0000;
      end else if (sum > 48'sh7fff) begin
        speed_req <= 16'sh7fff;
      end else if (sum < -48'sh8000) begin
        speed_req <= -16'sh8000;
      end else begin
        speed_req <= sum[15:0]; // [RULE1] [RULE3]
      end
    end
  end

endmodule
`default_nettype wire

/* tb/can_controller_model.sv */
`timescale 1ns/1ps
`default_nettype none
module can_controller_model (
  input wire logic clk,
  output logic sync_rx,
  output logic [1:0] sync_type,
  input wire logic fb_valid,
  input wire logic [31:0] fb_position
);
  int tx_count = 0;
  logic [31:0] last_pos = 32'h0;

  initial begin
    sync_rx = 1'b0;
    sync_type = 2'h3;
  end

  // Type only counts during the pulse; it is scrambled afterwards so a
  // design that samples it late picks up the wrong type
  task automatic send_sync(input logic [1:0] t);
    @(negedge clk);
    sync_rx = 1'b1;
    sync_type = t;
    @(negedge clk);
    sync_rx = 1'b0;
    sync_type = ~t;
  endtask

  always @(posedge clk) begin
    if (fb_valid === 1'b1) begin
      tx_count++;
      last_pos = fb_position;
    end
  end
endmodule
`default_nettype wire

/* tb/can_synced_position_loop_test.sv */
`timescale 1ns/1ps
`default_nettype none
module can_synced_position_loop_test;
  import pos_loop_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [3:0] op_mode = 4'h0;
  logic fb_source_select = 1'b0;
  logic [15:0] bit_rate_select = 16'h0000;
  logic [15:0] pos_gain = 16'h0010;
  logic [31:0] resolver_pos = 32'h00000f00;
  logic [31:0] encoder_pos = 32'h00002000;
  logic [31:0] shaft_angle = 32'h00000000;
  logic sync_rx;
  logic [1:0] sync_rx_type;
  logic reg_wr = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic [15:0] speed_request;
  logic [31:0] cur_pos;
  logic [31:0] err_acc;
  logic fb_tx_valid;
  logic [31:0] fb_tx_position;
  logic [15:0] reply_status;
  logic reply_short;
  logic rate_low_speed;
  logic rate_default_selected;
  int mismatches = 0;
  int total_checks = 0;

  always #12.5 mclk = ~mclk;

  can_synced_position_loop #(.GAIN_SHIFT(4)) i_dut (
    .MCLK(mclk), .RST(rst), .CE(ce), .OP_MODE(op_mode),
    .FB_SOURCE_SELECT(fb_source_select), .BIT_RATE_SELECT(bit_rate_select),
    .POS_GAIN(pos_gain), .RESOLVER_POS(resolver_pos), .ENCODER_POS(encoder_pos),
    .SHAFT_ANGLE(shaft_angle), .SYNC_RX(sync_rx), .SYNC_RX_TYPE(sync_rx_type),
    .REG_WR(reg_wr), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .SPEED_REQUEST(speed_request), .CURRENT_MOTOR_POSITION(cur_pos),
    .POSITION_ERROR_ACC(err_acc), .FB_TX_VALID(fb_tx_valid),
    .FB_TX_POSITION(fb_tx_position), .REPLY_STATUS(reply_status),
    .REPLY_SHORT(reply_short), .RATE_LOW_SPEED(rate_low_speed),
    .RATE_DEFAULT_SELECTED(rate_default_selected)
  );

  can_controller_model ctrl (
    .clk(mclk), .sync_rx(sync_rx), .sync_type(sync_rx_type),
    .fb_valid(fb_tx_valid), .fb_position(fb_tx_position)
  );

  task automatic end_sim();
    if (mismatches == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(negedge mclk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  // Called on a falling edge: read data is combinational, so it is taken just
  // after the address settles, and the next drive waits for the next falling edge
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr = a;
    #1;
    chk($sformatf("reg %0h", a), 32'(reg_rdata), 32'(e));
    @(negedge mclk);
  endtask

  task automatic do_sync(input logic [1:0] t, input logic [15:0] w, input logic exp);
    ctrl.send_sync(t);
    rd(REG_MODE_CTRL, w | 16'h0100);
    chk("fb_tx_valid", 32'(fb_tx_valid), 32'(exp));
    if (exp) chk("fb_tx_position", fb_tx_position, 32'h00000f00);
    rd(REG_ACTIVE_FF, 16'h0064);
    rd(REG_ACTIVE_REF_LO, 16'h1000);
    rd(REG_TX_POS_LO, 16'h0f00);
    rd(REG_MODE_CTRL, w);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    cyc(6);
    rst = 1'b0;
    for (int a = 0; a < 12; a++) rd(4'(a), 16'h0000);
    wr(REG_STATUS_A, 16'ha5c3);
    rd(REG_STATUS_A, 16'ha5c3);
    wr(REG_ACTIVE_REF_LO, 16'hffff);
    rd(REG_ACTIVE_REF_LO, 16'h0000);
    wr(REG_STATUS_B, 16'h1234);
    wr(REG_MODE_CTRL, 16'h0010);
    chk("rate_default", 32'(rate_default_selected), 32'h1);
    chk("rate_low", 32'(rate_low_speed), 32'h1);
    chk("reply_status", 32'(reply_status), 32'h1234);
    chk("reply_short", 32'(reply_short), 32'h0);
    wr(REG_MODE_CTRL, 16'h0008);
    chk("rate_low", 32'(rate_low_speed), 32'h0);
    cyc(1);
    chk("reply_status", 32'(reply_status), 32'h0034);
    chk("reply_short", 32'(reply_short), 32'h1);
    bit_rate_select = 16'h0005;
    wr(REG_MODE_CTRL, 16'h0010);
    chk("rate_default", 32'(rate_default_selected), 32'h0);
    chk("rate_low", 32'(rate_low_speed), 32'h0);
    fb_source_select = 1'b1;
    cyc(1);
    chk("motor_pos", cur_pos, 32'h00002000);
    fb_source_select = 1'b0;
    cyc(1);
    chk("motor_pos", cur_pos, 32'h00000f00);
    // A write while the clock enable is low must not be taken
    ce = 1'b0;
    wr(REG_RECEIVED_FF, 16'h0fff);
    ce = 1'b1;
    rd(REG_RECEIVED_FF, 16'h0000);
    op_mode = MODE_CAN_POSITION;
    wr(REG_RECEIVED_FF, 16'h0064);
    wr(REG_RX_POS_LO, 16'h1000);
    for (int en = 0; en < 2; en++) begin
      wr(REG_MODE_CTRL, en ? 16'h0040 : 16'h0004);
      for (int t = 0; t < 2; t++) begin
        do_sync(2'(t), en ? 16'h0040 : 16'h0004, en == t);
      end
    end
    chk("tx_count", 32'(ctrl.tx_count), 32'h2);
    chk("fb_last_pos", ctrl.last_pos, 32'h00000f00);
    cyc(3);
    chk("speed_req", 32'(speed_request), 32'h0164);
    op_mode = 4'h0;
    cyc(3);
    chk("speed_req", 32'(speed_request), 32'h0);
    shaft_angle = 32'h00012345;
    wr(REG_MODE_CTRL, 16'h0800);
    cyc(1);
    chk("motor_pos", cur_pos, 32'h00012345);
    chk("err_acc", err_acc, 32'h0);
    rd(REG_ACTIVE_REF_LO, 16'h2345);
    rd(REG_ACTIVE_REF_HI, 16'h0001);
    rd(REG_MODE_CTRL, 16'h0000);
    // Run the loop with a real error so the accumulator is non-zero again
    resolver_pos = 32'h00001000;
    op_mode = MODE_CAN_POSITION;
    cyc(3);
    chk("err_acc", err_acc, 32'hfffffd00);
    op_mode = 4'h0;
    wr(REG_MODE_CTRL, 16'h1000);
    cyc(1);
    rd(REG_ACTIVE_REF_LO, 16'h2445);
    rd(REG_ACTIVE_REF_HI, 16'h0001);
    chk("err_acc", err_acc, 32'h0);
    rd(REG_MODE_CTRL, 16'h0000);
    wr(REG_MODE_CTRL, 16'h0400);
    cyc(1);
    chk("motor_pos", cur_pos, 32'h0);
    rd(REG_ACTIVE_REF_LO, 16'h0000);
    rd(REG_ACTIVE_REF_HI, 16'h0000);
    rd(REG_TX_POS_LO, 16'h0000);
    rd(REG_MODE_CTRL, 16'h0000);
    end_sim();
  end

  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    end_sim();
  end
endmodule
`default_nettype wire
